// *** inc/sram_defines.svh ***
`ifndef SRAM_DEFINES_SVH
`define SRAM_DEFINES_SVH

// bus geometry
`define SRAM_DATA_W 36
`define SRAM_ADDR_W 20
`define SRAM_LANES 4
`define SRAM_LANE_W 9
`define SRAM_BURST_W 2

// lane patterns
`define SRAM_LANES_ALL 4'hF
`define SRAM_LANES_NONE 4'h0

// reset values of the pin synchronisers (inactive levels)
`define SRAM_OE_N_RST 1'h1
`define SRAM_SLEEP_RST 1'h0

// burst offset of the first beat and of the last beat before the wrap
`define SRAM_BURST_FIRST 2'h0
`define SRAM_BURST_LAST 2'h3

`endif

// *** inc/sram_pkg.sv ***
package sram_pkg;

	// state of the device as seen from the bus
	typedef enum logic [1:0] {
		ST_DESELECTED,
		ST_ACTIVE,
		ST_SLEEP
	} bus_state_t;

endpackage

// *** inc/burst_if.sv ***
`include "sram_defines.svh"

interface burst_if;
	logic load;
	logic step;
	logic linear;
	logic [`SRAM_ADDR_W-1:0] base_addr;
	logic [`SRAM_ADDR_W-1:0] cur_addr;
	logic [`SRAM_ADDR_W-1:0] next_addr;

	modport ctrl (
		output load,
		output step,
		output linear,
		output base_addr,
		input cur_addr,
		input next_addr
	);

	modport cnt (
		input load,
		input step,
		input linear,
		input base_addr,
		output cur_addr,
		output next_addr
	);
endinterface

// *** design/burst_counter.sv ***
`include "sram_defines.svh"

module burst_counter import sram_pkg::*; (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	// burst control
	burst_if.cnt bif
);

	logic [`SRAM_ADDR_W-1:0] base_r;
	logic [`SRAM_BURST_W-1:0] off_r;
	logic linear_r;

	function automatic logic [`SRAM_ADDR_W-1:0] beat_addr(
		input logic [`SRAM_ADDR_W-1:0] base,
		input logic [`SRAM_BURST_W-1:0] off,
		input logic linear
	);
		logic [`SRAM_BURST_W-1:0] low;
		low = linear ? base[`SRAM_BURST_W-1:0] + off : base[`SRAM_BURST_W-1:0] ^ off;
		return {base[`SRAM_ADDR_W-1:`SRAM_BURST_W], low};
	endfunction

	// two-bit offset wraps after the fourth beat
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			off_r <= `SRAM_BURST_FIRST;
		end else if (bif.load) begin
			off_r <= `SRAM_BURST_FIRST;
		end else if (bif.step) begin
			off_r <= off_r + 2'h1;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			base_r <= '0;
			linear_r <= 1'b0;
		end else if (bif.load) begin
			base_r <= bif.base_addr;
			linear_r <= bif.linear;
		end
	end

	assign bif.cur_addr = beat_addr(base_r, off_r, linear_r);
	assign bif.next_addr = beat_addr(base_r, off_r + 2'h1, linear_r);

	AST_BURST_HOLD: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		(!bif.step && !bif.load) |=> $stable(bif.cur_addr))
		else $error("burst address moved while not stepped");

	AST_BURST_WRAP: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		(bif.step && !bif.load && off_r == `SRAM_BURST_LAST) |=> (off_r == `SRAM_BURST_FIRST && $stable(base_r)))
		else $error("burst did not wrap to its start after the fourth beat");

endmodule // burst_counter

// *** design/sync_sram_bus.sv ***
`include "sram_defines.svh"

module sync_sram_bus import sram_pkg::*; (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	// address and strobes
	input wire logic [`SRAM_ADDR_W-1:0] addr_in,
	input wire logic processor_address_strobe_n_in,
	input wire logic controller_address_strobe_n_in,
	input wire logic burst_step_n_in,
	input wire logic linear_burst_in,
	// chip enables
	input wire logic chip_select_first_n_in,
	input wire logic chip_select_second_in,
	input wire logic chip_select_third_n_in,
	// write controls
	input wire logic global_write_n_in,
	input wire logic byte_write_gate_n_in,
	input wire logic [`SRAM_LANES-1:0] byte_lane_select_n_in,
	// asynchronous pins
	input wire logic output_enable_n_in,
	input wire logic sleep_request_in,
	// data bus
	input wire logic [`SRAM_DATA_W-1:0] dq_in,
	output logic [`SRAM_DATA_W-1:0] dq_out,
	output logic dq_oe_out,
	// status
	output logic sleep_active_out
);

	function automatic logic chip_selected(input logic first_n, input logic second, input logic third_n);
		return !first_n && second && !third_n;
	endfunction

	function automatic logic [`SRAM_LANES-1:0] lane_mask(
		input logic global_n,
		input logic gate_n,
		input logic [`SRAM_LANES-1:0] lanes_n
	);
		if (!global_n) begin
			return `SRAM_LANES_ALL;
		end else if (!gate_n) begin
			return ~lanes_n;
		end
		return `SRAM_LANES_NONE;
	endfunction

	logic [`SRAM_DATA_W-1:0] mem_r [0:(1<<`SRAM_ADDR_W)-1];
	logic oe_meta_r;
	logic oe_sync_r;
	logic sleep_meta_r;
	logic sleep_sync_r;
	bus_state_t state_r;
	bus_state_t state_nxt;
	logic write_park_r;
	logic rd_p1_r;
	logic [`SRAM_ADDR_W-1:0] addr_p1_r;
	logic drive_r;
	logic [`SRAM_DATA_W-1:0] rdata_r;

	logic sel;
	logic strobe;
	logic proc_strobe;
	logic new_access;
	logic deselect;
	logic awake;
	logic cont;
	logic acc_valid;
	logic acc_write;
	logic acc_read;
	logic [`SRAM_LANES-1:0] wmask;
	logic [`SRAM_ADDR_W-1:0] acc_addr;

	burst_if bif ();

	burst_counter u_burst (
		.ref_clk_in(ref_clk_in),
		.resetn_in(resetn_in),
		.bif(bif)
	);

	// asynchronous pins pass two flops
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			oe_meta_r <= `SRAM_OE_N_RST;
			oe_sync_r <= `SRAM_OE_N_RST;
			sleep_meta_r <= `SRAM_SLEEP_RST;
			sleep_sync_r <= `SRAM_SLEEP_RST;
		end else begin
			oe_meta_r <= output_enable_n_in;
			oe_sync_r <= oe_meta_r;
			sleep_meta_r <= sleep_request_in;
			sleep_sync_r <= sleep_meta_r;
		end
	end

	// access decode
	assign sel = chip_selected(chip_select_first_n_in, chip_select_second_in, chip_select_third_n_in);
	assign awake = !sleep_sync_r && state_r != ST_SLEEP;
	assign strobe = !processor_address_strobe_n_in || !controller_address_strobe_n_in;
	assign proc_strobe = !processor_address_strobe_n_in;
	assign new_access = awake && strobe && sel;
	assign deselect = awake && strobe && !sel;
	assign cont = awake && !strobe && state_r == ST_ACTIVE;
	assign acc_valid = new_access || cont;
	assign wmask = lane_mask(global_write_n_in, byte_write_gate_n_in, byte_lane_select_n_in);
	// a selected processor strobe always opens a read; write controls count from the next cycle
	assign acc_write = acc_valid && !(new_access && proc_strobe) && wmask != `SRAM_LANES_NONE;
	assign acc_read = acc_valid && !acc_write && (new_access || !write_park_r);

	always_comb begin
		if (new_access) begin
			acc_addr = addr_in;
		end else if (!burst_step_n_in) begin
			acc_addr = bif.next_addr;
		end else begin
			acc_addr = bif.cur_addr;
		end
	end

	assign bif.load = new_access;
	assign bif.step = cont && !burst_step_n_in;
	assign bif.linear = linear_burst_in;
	assign bif.base_addr = addr_in;

	// bus state
	always_comb begin
		state_nxt = state_r;
		if (sleep_sync_r) begin
			state_nxt = ST_SLEEP;
		end else begin
			unique case (state_r)
				ST_SLEEP: state_nxt = ST_DESELECTED;
				ST_DESELECTED: state_nxt = new_access ? ST_ACTIVE : ST_DESELECTED;
				ST_ACTIVE: state_nxt = deselect ? ST_DESELECTED : ST_ACTIVE;
			endcase
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			state_r <= ST_DESELECTED;
		end else begin
			state_r <= state_nxt;
		end
	end

	// write parks the data bus until a fresh strobe
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			write_park_r <= 1'b0;
		end else if (acc_write) begin
			write_park_r <= 1'b1;
		end else if (new_access || !awake) begin
			write_park_r <= 1'b0;
		end
	end

	// self-timed byte-lane writes
	always_ff @(posedge ref_clk_in) begin
		if (acc_write) begin
			for (int i = 0; i < `SRAM_LANES; i++) begin
				if (wmask[i]) begin
					mem_r[acc_addr][i*`SRAM_LANE_W +: `SRAM_LANE_W] <= dq_in[i*`SRAM_LANE_W +: `SRAM_LANE_W];
				end
			end
		end
	end

	// read pipeline: address stage then output stage
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			rd_p1_r <= 1'b0;
			addr_p1_r <= '0;
		end else begin
			rd_p1_r <= acc_read;
			addr_p1_r <= acc_addr;
		end
	end

	// the output stage keeps driving one cycle past a deselect
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			drive_r <= 1'b0;
			rdata_r <= '0;
		end else begin
			drive_r <= rd_p1_r && !sleep_sync_r;
			if (rd_p1_r) begin
				rdata_r <= mem_r[addr_p1_r];
			end
		end
	end

	assign dq_out = rdata_r;
	assign dq_oe_out = drive_r && !oe_sync_r && state_r != ST_SLEEP;
	assign sleep_active_out = state_r == ST_SLEEP;

	AST_SELECT_DECODE: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		(awake && strobe && (chip_select_first_n_in || !chip_select_second_in || chip_select_third_n_in))
		|=> (state_r == ST_DESELECTED && !rd_p1_r))
		else $error("strobe with an inactive enable did not deselect");

	AST_FULL_WRITE: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		((cont || (new_access && !proc_strobe))
		&& (!global_write_n_in || (!byte_write_gate_n_in && byte_lane_select_n_in == `SRAM_LANES_NONE)))
		|-> (acc_write && wmask == `SRAM_LANES_ALL))
		else $error("full-width write not decoded");

	AST_WRITE_FLOATS: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		acc_write |-> ##2 !dq_oe_out)
		else $error("data bus driven two cycles after a write");

	AST_PARK_HOLDS: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		(write_park_r && !new_access) |=> !rd_p1_r ##1 !drive_r)
		else $error("read started after a write without a new strobe");

	AST_SLEEP_EXIT: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		(state_r == ST_SLEEP && !sleep_sync_r) |-> !dq_oe_out ##1 !dq_oe_out ##1 !dq_oe_out)
		else $error("data bus driven while leaving sleep");

	AST_BURST_REPEAT: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		(cont && burst_step_n_in) |-> (acc_addr == bif.cur_addr))
		else $error("unstepped burst cycle left its location");

endmodule // sync_sram_bus

// *** tb/sram_ctrl_model.sv ***
`include "sram_defines.svh"

module sram_ctrl_model (
	// clock
	input wire logic ref_clk_in,
	// bus towards the memory
	output logic [`SRAM_ADDR_W-1:0] addr_out,
	output logic processor_address_strobe_n_out,
	output logic controller_address_strobe_n_out,
	output logic burst_step_n_out,
	output logic linear_burst_out,
	output logic chip_select_first_n_out,
	output logic chip_select_second_out,
	output logic chip_select_third_n_out,
	output logic global_write_n_out,
	output logic byte_write_gate_n_out,
	output logic [`SRAM_LANES-1:0] byte_lane_select_n_out,
	output logic sleep_request_out,
	output logic [`SRAM_DATA_W-1:0] dq_out
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		{processor_address_strobe_n_out, controller_address_strobe_n_out, burst_step_n_out} = 3'h7;
		{chip_select_first_n_out, chip_select_second_out, chip_select_third_n_out} = 3'h5;
		{global_write_n_out, byte_write_gate_n_out, byte_lane_select_n_out} = 6'h3F;
		{linear_burst_out, sleep_request_out} = 2'h0;
		addr_out = '0;
		dq_out = '0;
	end

	// st = {processor, controller, step}, ce = enables active, wr: 1 global, 2 all lanes
	task automatic go(input logic [2:0] st, ce, input logic [`SRAM_ADDR_W-1:0] a, input logic [1:0] wr,
		input logic [`SRAM_DATA_W-1:0] d);
		@(negedge ref_clk_in);
		{processor_address_strobe_n_out, controller_address_strobe_n_out, burst_step_n_out} = ~st;
		{chip_select_first_n_out, chip_select_second_out, chip_select_third_n_out} = ce ^ 3'h5;
		addr_out = a;
		global_write_n_out = wr != 2'h1;
		byte_write_gate_n_out = wr != 2'h2;
		byte_lane_select_n_out = wr == 2'h2 ? `SRAM_LANES_NONE : `SRAM_LANES_ALL;
		// unused data lines toggle so a stale value never looks valid
		dq_out = wr != 2'h0 ? d : ~dq_out;
	endtask

	// burst order takes effect at the next strobe
	task automatic set_order(input logic lin);
		linear_burst_out = lin;
	endtask

	task automatic doze(input logic s);
		if (s) begin
			go(3'h2, 3'h3, addr_out, 2'h0, dq_out);
			go(3'h0, 3'h3, addr_out, 2'h0, dq_out);
		end
		@(negedge ref_clk_in);
		sleep_request_out = s;
	endtask
endmodule // sram_ctrl_model

// *** tb/testbench.sv ***
`include "sram_defines.svh"

module testbench;
	timeunit 1ns;
	timeprecision 100ps;

	logic ref_clk_in, resetn_in, output_enable_n_in, dq_oe_out, sleep_active_out, linear_burst_in;
	logic processor_address_strobe_n_in, controller_address_strobe_n_in, burst_step_n_in, sleep_request_in;
	logic chip_select_first_n_in, chip_select_second_in, chip_select_third_n_in;
	logic global_write_n_in, byte_write_gate_n_in;
	logic [`SRAM_LANES-1:0] byte_lane_select_n_in;
	logic [`SRAM_ADDR_W-1:0] addr_in, b;
	logic [`SRAM_DATA_W-1:0] dq_in, dq_out;
	logic [`SRAM_DATA_W-1:0] mem [logic [`SRAM_ADDR_W-1:0]];
	int errors = 0;
	int n_compared = 0;

	sync_sram_bus dut_u (.ref_clk_in, .resetn_in, .addr_in, .processor_address_strobe_n_in,
		.controller_address_strobe_n_in, .burst_step_n_in, .linear_burst_in, .chip_select_first_n_in,
		.chip_select_second_in, .chip_select_third_n_in, .global_write_n_in, .byte_write_gate_n_in,
		.byte_lane_select_n_in, .output_enable_n_in, .sleep_request_in, .dq_in, .dq_out, .dq_oe_out,
		.sleep_active_out);

	sram_ctrl_model ctrl_u (.ref_clk_in, .addr_out(addr_in), .linear_burst_out(linear_burst_in),
		.processor_address_strobe_n_out(processor_address_strobe_n_in),
		.controller_address_strobe_n_out(controller_address_strobe_n_in), .burst_step_n_out(burst_step_n_in),
		.chip_select_first_n_out(chip_select_first_n_in), .chip_select_second_out(chip_select_second_in),
		.chip_select_third_n_out(chip_select_third_n_in), .global_write_n_out(global_write_n_in),
		.byte_write_gate_n_out(byte_write_gate_n_in), .byte_lane_select_n_out(byte_lane_select_n_in),
		.sleep_request_out(sleep_request_in), .dq_out(dq_in));

	function automatic logic [`SRAM_ADDR_W-1:0] beat(input logic [`SRAM_ADDR_W-1:0] a, input int k, input bit lin);
		beat = {a[`SRAM_ADDR_W-1:2], lin ? a[1:0] + 2'(k) : a[1:0] ^ 2'(k)};
	endfunction

	task automatic chk(input logic [`SRAM_DATA_W-1:0] got, exp, input string m);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask

	task automatic wr(input logic [`SRAM_ADDR_W-1:0] a, input logic [1:0] how);
		mem[a] = 36'({$urandom, $urandom});
		ctrl_u.go(3'h2, 3'h7, a, how, mem[a]);
		repeat (2) ctrl_u.go(3'h0, 3'h7, a, 2'h0, '0);
		@(negedge ref_clk_in) chk(dq_oe_out, 1'h0, "bus driven after write");
	endtask

	// read opened by either strobe, looked at two edges after the strobe
	task automatic rd(input logic [`SRAM_ADDR_W-1:0] a, input logic [2:0] ce, input logic en);
		ctrl_u.go($urandom_range(1) ? 3'h4 : 3'h2, ce, a, 2'h0, '0);
		ctrl_u.go(3'h0, ce, a, 2'h0, '0);
		repeat (2) @(negedge ref_clk_in);
		chk(dq_oe_out, en, "output enable");
		if (en) chk(dq_out, mem[a], "read data");
		ctrl_u.go(3'h2, 3'h3, a, 2'h0, '0);
		repeat (2) ctrl_u.go(3'h0, 3'h3, a, 2'h0, '0);
	endtask

	task automatic finish_test();
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	initial begin
		ref_clk_in = 1'h0;
		forever #12.5 ref_clk_in = ~ref_clk_in;
	end

	initial begin
		#(3000 * 25);
		errors++;
		finish_test();
	end

	initial begin
		resetn_in = 1'h0;
		output_enable_n_in = 1'h0;
		void'($urandom(41425));
		repeat (16) @(negedge ref_clk_in);
		resetn_in = 1'h1;
		chk(sleep_active_out, 1'h0, "sleep after reset");
		for (int i = 0; i < 20; i++) begin
			b = 20'($urandom);
			wr(b, 2'h1 + 2'($urandom_range(1)));
			rd(b, 3'h7, 1'h1);
			rd(b, 3'h7 ^ 3'(1 << (i % 3)), 1'h0);
		end
		for (int m = 0; m < 2; m++) begin
			b = 20'($urandom);
			for (int k = 0; k < 4; k++) wr(beat(b, k, m[0]), 2'h1);
			ctrl_u.go(3'h2, 3'h7, b, 2'h0, '0);
			ctrl_u.set_order(m[0]);
			// four steps, then the step input stays idle; data of edge j shows after edge j+1
			for (int k = 1; k < 9; k++) begin
				ctrl_u.go(k < 5 ? 3'h1 : 3'h0, 3'h7, b, 2'h0, '0);
				if (k > 1) chk(dq_out, mem[beat(b, k < 6 ? k - 2 : 0, m[0])], "burst beat");
			end
			rd(b, 3'h3, 1'h0);
		end
		ctrl_u.doze(1'h1);
		repeat (4) @(negedge ref_clk_in);
		chk({sleep_active_out, dq_oe_out}, 2'h2, "sleep entry");
		ctrl_u.doze(1'h0);
		repeat (4) @(negedge ref_clk_in);
		chk({sleep_active_out, dq_oe_out}, 2'h0, "sleep exit");
		// output enable pin high keeps the bus released during a read
		output_enable_n_in = 1'h1;
		rd(b, 3'h7, 1'h0);
		output_enable_n_in = 1'h0;
		rd(b, 3'h7, 1'h1);
		finish_test();
	end
endmodule // testbench
